//--- hw/ets_pkg.sv
// Constants, register map and carrier types for the event timestamp sample registers.
// Assumes a single 50 MHz clock and a time base that is already on that clock.
package ets_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Sizes
  localparam int UNIT_COUNT = 2;
  localparam int SLOT_COUNT = 2;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int IRQ_WIDTH = UNIT_COUNT * SLOT_COUNT;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] ADDR_SAMPLE4_NANOSECONDS = 12'h0578;
  localparam logic [11:0] ADDR_SAMPLE4_SECONDS = 12'h057c;
  localparam logic [11:0] ADDR_SAMPLE4_PHASE = 12'h0580;
  localparam logic [11:0] ADDR_SAMPLE5_NANOSECONDS = 12'h0584;
  localparam logic [11:0] ADDR_SAMPLE5_SECONDS = 12'h0588;
  localparam logic [11:0] ADDR_SAMPLE5_PHASE = 12'h058c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h0600;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h0604;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h0608;
  localparam logic [11:0] ADDR_CAPTURE_CONTROL = 12'h060c;

  // ==========================================================
  // Field positions and reset values
  localparam int EDGE_BIT = 30;
  localparam int NS_MSB = 29;
  localparam int PHASE_MSB = 2;
  localparam int COUNT_BITS = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ==========================================================
  // Sub-cycle phase codes within the 40 ns period
  localparam logic [2:0] PHASE_0NS = 3'h0;
  localparam logic [2:0] PHASE_8NS = 3'h1;
  localparam logic [2:0] PHASE_16NS = 3'h2;
  localparam logic [2:0] PHASE_24NS = 3'h3;
  localparam logic [2:0] PHASE_32NS = 3'h4;

  // ==========================================================
  // Capture ordinals (zero based) and the counter ceiling
  localparam logic [2:0] COUNT_SLOT4 = 3'h3;
  localparam logic [2:0] COUNT_SLOT5 = 3'h4;
  localparam logic [2:0] COUNT_DONE = 3'h5;

  // ==========================================================
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Free running time base presented by the clock block
  typedef struct packed {
    logic [31:0] seconds;
    logic [29:0] nanoseconds;
    logic [2:0] subcycle;
  } ets_time_type;

  // One recorded sample; stored as a whole so its fields never mix
  typedef struct packed {
    logic edge_rising;
    logic [29:0] nanoseconds;
    logic [31:0] seconds;
    logic [2:0] phase;
  } ets_sample_type;

endpackage : ets_pkg

//--- hw/ets_sample_regs.sv
// Event timestamp capture of the fourth and fifth samples, with AXI4-Lite register access.
// Assumes the time base is on clk; event pins are asynchronous and are synchronised here.
module ets_sample_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Time base and capture inputs
  input wire ets_pkg::ets_time_type time_base,
  input wire logic [ets_pkg::UNIT_COUNT-1:0] event_pin,
  input wire logic unit_index,
  // AXI4-Lite write address
  input wire logic [ets_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [ets_pkg::DATA_WIDTH-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ets_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [ets_pkg::DATA_WIDTH-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Declarations
  ets_pkg::ets_sample_type [ets_pkg::SLOT_COUNT-1:0] unit_slots [ets_pkg::UNIT_COUNT];
  logic [ets_pkg::IRQ_WIDTH-1:0] cap_event;
  logic [ets_pkg::UNIT_COUNT*ets_pkg::COUNT_BITS-1:0] count_all;
  logic [ets_pkg::UNIT_COUNT-1:0] rearm_pulse;
  logic [ets_pkg::IRQ_WIDTH-1:0] status_reg;
  logic [ets_pkg::IRQ_WIDTH-1:0] enable_reg;
  logic [ets_pkg::ADDR_WIDTH-1:0] awaddr_reg;
  logic aw_held_reg;
  logic [ets_pkg::DATA_WIDTH-1:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [ets_pkg::DATA_WIDTH-1:0] rdata_reg;
  logic wr_fire;
  logic wr_to_clear;
  logic wr_to_enable;
  logic wr_to_control;
  logic wr_known;
  logic [ets_pkg::DATA_WIDTH-1:0] rd_word;
  logic rd_known;
  ets_pkg::ets_sample_type rd_sample;
  logic [2:0] capture_phase;
  logic irq_reg;

  // ==========================================================
  // Sub-cycle phase encoding
  // sub-cycle codes
  // Third sub-cycle uses 010, keeping the 101 pattern free for the reserved range
  // fifth and reserved
  // Out of range indices clamp to the last legal code so 101-111 never appear
  always_comb
  begin
    case (time_base.subcycle)
      ets_pkg::PHASE_0NS: capture_phase = ets_pkg::PHASE_0NS;
      ets_pkg::PHASE_8NS: capture_phase = ets_pkg::PHASE_8NS;
      ets_pkg::PHASE_16NS: capture_phase = ets_pkg::PHASE_16NS;
      ets_pkg::PHASE_24NS: capture_phase = ets_pkg::PHASE_24NS;
      default: capture_phase = ets_pkg::PHASE_32NS;
    endcase
  end

  // ==========================================================
  // Per unit capture
  for (genvar u = 0; u < ets_pkg::UNIT_COUNT; u++)
  begin : g_unit
    logic [2:0] sync_reg;
    logic [ets_pkg::COUNT_BITS-1:0] count_reg;
    ets_pkg::ets_sample_type [ets_pkg::SLOT_COUNT-1:0] slot_reg;
    ets_pkg::ets_sample_type capture;
    logic edge_seen;
    logic take4;
    logic take5;

    // Two stage synchroniser, third stage only for edge detection
    // Not reset: it keeps tracking the pin through reset, so a pin that
    // idles high shows no false edge once reset is released
    always_ff @(posedge clk)
    begin
      sync_reg <= {sync_reg[1:0], event_pin[u]};
    end

    // Both edges count; stage 1 is the settled level after the edge
    assign edge_seen = sync_reg[1] ^ sync_reg[2];
    assign take4 = edge_seen && (count_reg == ets_pkg::COUNT_SLOT4) && !rearm_pulse[u];
    assign take5 = edge_seen && (count_reg == ets_pkg::COUNT_SLOT5) && !rearm_pulse[u];

    // Capture word assembled from one instant of the time base
    // edge polarity
    assign capture.edge_rising = sync_reg[1];
    assign capture.nanoseconds = time_base.nanoseconds;
    assign capture.seconds = time_base.seconds;
    assign capture.phase = capture_phase;

    // Sample ordinal counter; saturates so later edges are not recorded
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        count_reg <= '0;
      else if (rearm_pulse[u])
        count_reg <= '0;
      else if (edge_seen && count_reg != ets_pkg::COUNT_DONE)
        count_reg <= count_reg + 3'h1;
    end

    // whole sample written at once
    // Storing the packed struct keeps edge, time and phase from one capture
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        slot_reg <= '0;
      else
      begin
        if (take4)
          slot_reg[0] <= capture;
        if (take5)
          slot_reg[1] <= capture;
      end
    end

    assign unit_slots[u] = slot_reg;
    assign cap_event[2*u +: 2] = {take5, take4};
    assign count_all[ets_pkg::COUNT_BITS*u +: ets_pkg::COUNT_BITS] = count_reg;
  end

  // ==========================================================
  // Write channel acceptance
  // Address and data are held independently; the response follows both
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  // Write address holding register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_reg <= 1'b0;
  end

  // Write data holding register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= ets_pkg::RESET_WORD;
      wstrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_reg <= 1'b0;
  end

  // Write decode; only byte lane 0 carries writable bits
  assign wr_to_clear = wr_fire && awaddr_reg == ets_pkg::ADDR_IRQ_CLEAR && wstrb_reg[0];
  assign wr_to_enable = wr_fire && awaddr_reg == ets_pkg::ADDR_IRQ_ENABLE && wstrb_reg[0];
  assign wr_to_control = wr_fire && awaddr_reg == ets_pkg::ADDR_CAPTURE_CONTROL && wstrb_reg[0];
  assign rearm_pulse = wr_to_control ? wdata_reg[ets_pkg::UNIT_COUNT-1:0] : '0;

  // Known write targets; sample words accept writes and ignore them
  always_comb
  begin
    case (awaddr_reg)
      ets_pkg::ADDR_SAMPLE4_NANOSECONDS,
      ets_pkg::ADDR_SAMPLE4_SECONDS,
      ets_pkg::ADDR_SAMPLE4_PHASE,
      ets_pkg::ADDR_SAMPLE5_NANOSECONDS,
      ets_pkg::ADDR_SAMPLE5_SECONDS,
      ets_pkg::ADDR_SAMPLE5_PHASE,
      ets_pkg::ADDR_IRQ_STATUS,
      ets_pkg::ADDR_IRQ_CLEAR,
      ets_pkg::ADDR_IRQ_ENABLE,
      ets_pkg::ADDR_CAPTURE_CONTROL: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ets_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_known ? ets_pkg::RESP_OKAY : ets_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // ==========================================================
  // Interrupt status, enable and clear
  // Set wins over clear so a capture in the clearing cycle is not lost
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      status_reg <= '0;
    else if (wr_to_clear)
      status_reg <= (status_reg & ~wdata_reg[ets_pkg::IRQ_WIDTH-1:0]) | cap_event;
    else
      status_reg <= status_reg | cap_event;
  end

  // Enable mask written by software
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      enable_reg <= '0;
    else if (wr_to_enable)
      enable_reg <= wdata_reg[ets_pkg::IRQ_WIDTH-1:0];
  end

  // Interrupt level from a flip-flop; it trails the status by one cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & enable_reg);
  end

  assign irq = irq_reg;

  // ==========================================================
  // Read decode
  // unit pointer selects
  // Pointer is sampled with the read address, so software sets it first
  assign rd_sample = (s_axi_araddr < ets_pkg::ADDR_SAMPLE5_NANOSECONDS) ?
    unit_slots[unit_index][0] : unit_slots[unit_index][1];

  always_comb
  begin
    rd_word = ets_pkg::RESET_WORD;
    rd_known = 1'b1;
    case (s_axi_araddr)
      ets_pkg::ADDR_SAMPLE4_NANOSECONDS,
      ets_pkg::ADDR_SAMPLE5_NANOSECONDS:
        rd_word = {1'b0, rd_sample.edge_rising, rd_sample.nanoseconds};
      ets_pkg::ADDR_SAMPLE4_SECONDS,
      ets_pkg::ADDR_SAMPLE5_SECONDS:
        rd_word = rd_sample.seconds;
      ets_pkg::ADDR_SAMPLE4_PHASE,
      ets_pkg::ADDR_SAMPLE5_PHASE:
        rd_word = {{(ets_pkg::DATA_WIDTH-ets_pkg::PHASE_MSB-1){1'b0}}, rd_sample.phase};
      ets_pkg::ADDR_IRQ_STATUS:
        rd_word = {{(ets_pkg::DATA_WIDTH-ets_pkg::IRQ_WIDTH){1'b0}}, status_reg};
      ets_pkg::ADDR_IRQ_CLEAR:
        rd_word = ets_pkg::RESET_WORD;
      ets_pkg::ADDR_IRQ_ENABLE:
        rd_word = {{(ets_pkg::DATA_WIDTH-ets_pkg::IRQ_WIDTH){1'b0}}, enable_reg};
      ets_pkg::ADDR_CAPTURE_CONTROL:
        rd_word = {{(ets_pkg::DATA_WIDTH-ets_pkg::UNIT_COUNT*ets_pkg::COUNT_BITS){1'b0}},
          count_all};
      default:
        rd_known = 1'b0;
    endcase
  end

  // ==========================================================
  // Read channel; one read outstanding, data registered
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= ets_pkg::RESP_OKAY;
      rdata_reg <= ets_pkg::RESET_WORD;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_known ? ets_pkg::RESP_OKAY : ets_pkg::RESP_SLVERR;
      rdata_reg <= rd_word;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule : ets_sample_regs

//--- test/ets_sample_regs_asserts.sv
// Checker for the sample register block: bus handshakes and field ranges.
// Assumes it is bound to ets_sample_regs and sees its ports only.
module ets_sample_regs_asserts
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [ets_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ets_pkg::DATA_WIDTH-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Write channel: answer, hold and refusal
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  // ==========================================================
  // Read channel: answer, hold and refusal
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer changed");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  // Addresses below 0x578 or above 0x60c answer with an error and zero data
  chk_unmapped_error: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr < 12'h0578 || s_axi_araddr > 12'h060c)
    |=> s_axi_rresp == ets_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // ==========================================================
  // Field ranges; reserved phase codes must never appear
  chk_phase_range: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr == ets_pkg::ADDR_SAMPLE4_PHASE || s_axi_araddr == ets_pkg::ADDR_SAMPLE5_PHASE)
    |=> s_axi_rdata[31:3] == 29'h0000_0000 && s_axi_rdata[2:0] <= ets_pkg::PHASE_32NS)
    else $error("phase code out of range");
  chk_ns_reserved: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr == 12'h0578 || s_axi_araddr == 12'h0584) |=> !s_axi_rdata[31])
    else $error("nanoseconds top bit set");
endmodule : ets_sample_regs_asserts

bind ets_sample_regs ets_sample_regs_asserts chk (.clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- test/test_ets_sample_regs.sv
// Self-checking bench for the sample registers: captures, unit select, interrupts.
// Assumes one 50 MHz clock; the bench acts as AXI4-Lite master and event source.
module test_ets_sample_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic unit; logic [2:0] sub4; logic [2:0] sub5;
    logic [2:0] code4; logic [2:0] code5;} ets_row_type;
  // Subcycle indexes above four must report the last code
  ets_row_type rows [4] = '{'{1'b0, 3'h0, 3'h1, ets_pkg::PHASE_0NS, ets_pkg::PHASE_8NS},
    '{1'b1, 3'h2, 3'h3, ets_pkg::PHASE_16NS, ets_pkg::PHASE_24NS},
    '{1'b0, 3'h4, 3'h7, ets_pkg::PHASE_32NS, ets_pkg::PHASE_32NS},
    '{1'b1, 3'h5, 3'h6, ets_pkg::PHASE_32NS, ets_pkg::PHASE_32NS}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ets_pkg::ets_time_type time_base = '0;
  logic [1:0] event_pin = 2'h0;
  logic unit_index = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  ets_sample_regs DUT (.clk(clk), .sys_rst(sys_rst), .time_base(time_base),
    .event_pin(event_pin), .unit_index(unit_index), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

  // Clock and hang guard
  initial
  begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      mismatches = mismatches + 1;
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Handshakes are sampled mid-cycle, so the value equals what the next edge takes
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end while (!bh);
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
    end while (!rh);
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read

  // One pin edge, time base held until the capture has surely landed
  task automatic pulse(input logic u, input ets_pkg::ets_time_type t);
    time_base <= t;
    event_pin[u] <= ~event_pin[u];
    repeat (6) @(posedge clk);
  endtask : pulse

  // Main sequence
  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic [11:0] base;
    logic lvl [5];
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 12; a++)
    begin
      unit_index <= a[0];
      axi_read(ets_pkg::ADDR_SAMPLE4_NANOSECONDS + 12'(4 * (a / 2)), d, r);
      check("reset word", d, ets_pkg::RESET_WORD);
      check("read resp", {30'h0, r}, {30'h0, ets_pkg::RESP_OKAY});
    end
    for (int i = 0; i < 4; i++)
    begin
      axi_write(ets_pkg::ADDR_CAPTURE_CONTROL, rows[i].unit ? 32'h0000_0002 : 32'h0000_0001, r);
      for (int k = 0; k < 5; k++)
      begin
        lvl[k] = ~event_pin[rows[i].unit];
        pulse(rows[i].unit, {32'hc000_0000 + 32'(16 * i + k), 30'h3abc_0000 + 30'(16 * i + k),
          (k == 3) ? rows[i].sub4 : rows[i].sub5});
      end
      unit_index <= rows[i].unit;
      for (int s = 0; s < 2; s++)
      begin
        base = ets_pkg::ADDR_SAMPLE4_NANOSECONDS + 12'(12 * s);
        axi_read(base, d, r);
        check("nanoseconds", d, {1'b0, lvl[3 + s], 30'h3abc_0000 + 30'(16 * i + 3 + s)});
        axi_read(base + 12'h004, d, r);
        check("seconds", d, 32'hc000_0000 + 32'(16 * i + 3 + s));
        axi_read(base + 12'h008, d, r);
        check("phase", d, {29'h0, s ? rows[i].code5 : rows[i].code4});
      end
    end
    // Both units saturated at five edges
    axi_read(ets_pkg::ADDR_CAPTURE_CONTROL, d, r);
    check("sample counts", d, 32'h0000_002d);
    unit_index <= 1'b0;
    axi_read(ets_pkg::ADDR_SAMPLE4_SECONDS, d, r);
    check("unit zero", d, 32'hc000_0023);
    unit_index <= 1'b1;
    axi_read(ets_pkg::ADDR_SAMPLE4_SECONDS, d, r);
    check("unit one", d, 32'hc000_0033);
    // Read-only word ignores writes, unmapped place refuses
    axi_write(ets_pkg::ADDR_SAMPLE4_SECONDS, 32'hffff_ffff, r);
    check("read-only resp", {30'h0, r}, {30'h0, ets_pkg::RESP_OKAY});
    axi_read(ets_pkg::ADDR_SAMPLE4_SECONDS, d, r);
    check("read-only kept", d, 32'hc000_0033);
    axi_read(12'h0700, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, ets_pkg::RESP_SLVERR});
    check("unmapped data", d, ets_pkg::RESET_WORD);
    axi_write(12'h0700, 32'h0000_0001, r);
    check("unmapped write", {30'h0, r}, {30'h0, ets_pkg::RESP_SLVERR});
    // Pin left high across the coming reset; saturated count ignores this edge
    event_pin[0] <= 1'b1;
    // Interrupt raise, mask and clear
    axi_read(ets_pkg::ADDR_IRQ_STATUS, d, r);
    check("status", d, 32'h0000_000f);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    axi_write(ets_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001, r);
    check("irq raised", {31'h0, irq}, 32'h0000_0001);
    axi_write(ets_pkg::ADDR_IRQ_CLEAR, 32'h0000_0001, r);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    axi_read(ets_pkg::ADDR_IRQ_STATUS, d, r);
    check("status cleared", d, 32'h0000_000e);
    // Second reset in mid-run empties the slots again
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    axi_read(ets_pkg::ADDR_SAMPLE4_SECONDS, d, r);
    check("reset again", d, ets_pkg::RESET_WORD);
    axi_read(ets_pkg::ADDR_IRQ_ENABLE, d, r);
    check("enable reset", d, ets_pkg::RESET_WORD);
    axi_read(ets_pkg::ADDR_IRQ_STATUS, d, r);
    check("status reset", d, ets_pkg::RESET_WORD);
    check("irq reset", {31'h0, irq}, 32'h0000_0000);
    // A pin held high through reset must not count as an edge
    axi_read(ets_pkg::ADDR_CAPTURE_CONTROL, d, r);
    check("no false edge", d, ets_pkg::RESET_WORD);
    conclude();
  end
endmodule : test_ets_sample_regs
